// ### usimd_map.svh
// Constants for the unsigned saturating SIMD and byte abs-diff datapath.
// Assumes inclusion by the package and the datapath module only.
`ifndef USIMD_MAP_SVH
`define USIMD_MAP_SVH
`define USIMD_REG_FIELD_W  4
`define USIMD_REG_SP       4'hd
`define USIMD_REG_PC       4'hf
`define USIMD_ACC_NONE     4'hf
`define USIMD_HALF_MAX     16'hffff
`define USIMD_BYTE_MAX     8'hff
`define USIMD_RESULT_RST   32'h0000_0000
`endif

// ### usimd_pkg.sv
// Types for the unsigned saturating SIMD and byte abs-diff datapath.
// Assumes the constant header usimd_map.svh is on the include path.
`include "usimd_map.svh"
package usimd_pkg;
  typedef enum logic [2:0] {
    usimd_sat_add_sub_exchange_op,
    usimd_sat_sub_add_exchange_op,
    usimd_sat_halfword_subtract_op,
    usimd_sat_byte_subtract_op,
    usimd_byte_abs_diff_sum_op,
    usimd_byte_abs_diff_accumulate_op
  } usimd_op_e;

  typedef logic [`USIMD_REG_FIELD_W-1:0] usimd_reg_t;

  typedef struct packed {
    usimd_op_e  op;
    usimd_reg_t dest_reg_field;
    usimd_reg_t first_src_reg_field;
    usimd_reg_t second_src_reg_field;
    usimd_reg_t accumulator_reg_field;
    logic       cond_pass;
  } usimd_req_s;

  typedef struct packed {
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] acc;
  } usimd_opnd_s;

  typedef struct packed {
    logic        wr_en;
    usimd_reg_t  wr_reg;
    logic [31:0] data;
    logic        undef;
    logic        unpredictable;
    logic        eff_accumulate;
  } usimd_res_s;
endpackage

// ### usimd_alu.sv
// Single-cycle datapath for unsigned saturating halfword/byte ops and byte abs-diff sums.
// Assumes the decoder presents one request per cycle with operands already read.
`timescale 1ns/10ps
`include "usimd_map.svh"

// One unsigned lane: borrow-clamped difference and absolute magnitude
module usimd_lane_sub #(
  parameter int W = 8
) (
  // Lane operands
  input  wire logic [W-1:0] i_a,
  input  wire logic [W-1:0] i_b,
  // Lane results
  output logic      [W-1:0] o_sat_diff,
  output logic      [W-1:0] o_mag
);
  import usimd_pkg::*;

  logic [W:0]   diff;
  logic [W-1:0] neg;

  always_comb begin
    diff       = {1'b0, i_a} - {1'b0, i_b};
    neg        = {W{1'b0}} - diff[W-1:0];
    o_sat_diff = diff[W] ? {W{1'b0}} : diff[W-1:0];
    o_mag      = diff[W] ? neg : diff[W-1:0];
  end
endmodule

// Contract
// - add-sub exchange: lo=a.lo-b.hi, hi=a.hi+b.lo saturated
// - sub-add exchange: lo=a.lo+b.hi, hi=a.hi-b.lo saturated
// - halfword lanes clamp to zero through 65535
// - halfword subtract per lane, saturated, same lane
// - four byte subtracts, each clamped zero to 255
// - sum four byte absolute differences, low 32
// - accumulate variant adds accumulator, low 32 bits
// - accumulator field all ones means plain sum
// - option absent makes every operation undefined
// - write only when condition passes, else keep
module usimd_alu (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  // Option presence
  input  wire logic               i_dsp_present,
  // Request
  input  wire logic               i_valid,
  input  wire usimd_pkg::usimd_req_s  i_req,
  input  wire usimd_pkg::usimd_opnd_s i_opnd,
  // Result
  output logic                    o_valid,
  output usimd_pkg::usimd_res_s   o_res
);
  import usimd_pkg::*;

  logic [16:0]  hsum_hi;
  logic [15:0]  hdif_hi;
  logic [15:0]  hdif_lo;
  logic [15:0]  xdif_lo;
  logic [15:0]  xdif_hi;
  logic [31:0]  bmag;
  logic         dest_bad;
  logic         first_bad;
  logic         second_bad;
  logic         acc_bad;
  logic [16:0]  xsum_lo;
  logic [31:0]  bsub;
  logic [9:0]   sad;
  logic [31:0]  sad_acc;
  logic         accumulate;
  logic [31:0]  result;
  logic         valid;
  usimd_res_s   res;
  logic         next_valid;
  usimd_res_s   next_res;

  // Halfword subtract lanes clamp at zero on borrow
  usimd_lane_sub #(
    .W (16)
  ) xdif_lo_u (
    .i_a        (i_opnd.first[15:0]),
    .i_b        (i_opnd.second[31:16]),
    .o_sat_diff (xdif_lo),
    .o_mag      ()
  );

  usimd_lane_sub #(
    .W (16)
  ) xdif_hi_u (
    .i_a        (i_opnd.first[31:16]),
    .i_b        (i_opnd.second[15:0]),
    .o_sat_diff (xdif_hi),
    .o_mag      ()
  );

  usimd_lane_sub #(
    .W (16)
  ) hdif_lo_u (
    .i_a        (i_opnd.first[15:0]),
    .i_b        (i_opnd.second[15:0]),
    .o_sat_diff (hdif_lo),
    .o_mag      ()
  );

  usimd_lane_sub #(
    .W (16)
  ) hdif_hi_u (
    .i_a        (i_opnd.first[31:16]),
    .i_b        (i_opnd.second[31:16]),
    .o_sat_diff (hdif_hi),
    .o_mag      ()
  );

  // Four independent byte lanes share one lane cell
  for (genvar k = 0; k < 4; k++) begin : g_byte
    usimd_lane_sub #(
      .W (8)
    ) lane_u (
      .i_a        (i_opnd.first[8*k +: 8]),
      .i_b        (i_opnd.second[8*k +: 8]),
      .o_sat_diff (bsub[8*k +: 8]),
      .o_mag      (bmag[8*k +: 8])
    );
  end

  function automatic logic [15:0] sat16(input logic [16:0] v, input logic is_sub);
    logic [15:0] r;
    r = v[15:0];
    if (v[16]) begin
      r = is_sub ? 16'h0000 : `USIMD_HALF_MAX;
    end
    return r;
  endfunction

  always_comb begin
    hsum_hi = {1'b0, i_opnd.first[31:16]} + {1'b0, i_opnd.second[15:0]};
    xsum_lo = {1'b0, i_opnd.first[15:0]} + {1'b0, i_opnd.second[31:16]};
    sad     = 10'h000;
    for (int k = 0; k < 4; k++) begin
      sad = sad + {2'b00, bmag[8*k +: 8]};
    end
    sad_acc = i_opnd.acc + {22'h000000, sad};
    accumulate = (i_req.accumulator_reg_field != `USIMD_ACC_NONE);
  end

  always_comb begin
    result = `USIMD_RESULT_RST;
    unique case (i_req.op)
      usimd_sat_add_sub_exchange_op: begin
        result = {sat16(hsum_hi, 1'b0), xdif_lo};
      end
      usimd_sat_sub_add_exchange_op: begin
        result = {xdif_hi, sat16(xsum_lo, 1'b0)};
      end
      usimd_sat_halfword_subtract_op: begin
        result = {hdif_hi, hdif_lo};
      end
      usimd_sat_byte_subtract_op: begin
        result = bsub;
      end
      usimd_byte_abs_diff_sum_op: begin
        result = {22'h000000, sad};
      end
      usimd_byte_abs_diff_accumulate_op: begin
        result = accumulate ? sad_acc : {22'h000000, sad};
      end
      default: begin
        result = `USIMD_RESULT_RST;
      end
    endcase
  end

  // Misuse of stack pointer or program counter is flagged; the result is still computed
  always_comb begin
    dest_bad   = (i_req.dest_reg_field == `USIMD_REG_SP) ||
                 (i_req.dest_reg_field == `USIMD_REG_PC);
    first_bad  = (i_req.first_src_reg_field == `USIMD_REG_SP) ||
                 (i_req.first_src_reg_field == `USIMD_REG_PC);
    second_bad = (i_req.second_src_reg_field == `USIMD_REG_SP) ||
                 (i_req.second_src_reg_field == `USIMD_REG_PC);
    acc_bad    = (i_req.op == usimd_byte_abs_diff_accumulate_op) && accumulate &&
                 (i_req.accumulator_reg_field == `USIMD_REG_SP);
  end

  // Registered result; no status flag outputs exist, so flags stay untouched
  always_comb begin
    next_valid = i_valid;
    next_res = res;
    if (i_valid) begin
      next_res.undef = !i_dsp_present;
      next_res.wr_en = i_dsp_present && i_req.cond_pass;
      next_res.wr_reg = i_req.dest_reg_field;
      next_res.eff_accumulate = (i_req.op == usimd_byte_abs_diff_accumulate_op) && accumulate;
      next_res.unpredictable = dest_bad || first_bad || second_bad || acc_bad;
      if (next_res.wr_en) begin
        next_res.data = result;
      end
    end else begin
      next_res.wr_en = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      valid <= 1'b0;
      res   <= '0;
    end else begin
      valid <= next_valid;
      res   <= next_res;
    end
  end

  assign o_valid = valid;
  assign o_res   = res;
endmodule

// ### usimd_alu_checker.sv
// Port assertions for the unsigned SIMD datapath.
// Assumes one clock domain and a one-cycle answer.
`timescale 1ns/10ps
module usimd_alu_checker (
  input wire logic                   i_clk, i_resetn, i_dsp_present, i_valid, o_valid,
  input wire usimd_pkg::usimd_req_s  i_req,
  input wire usimd_pkg::usimd_opnd_s i_opnd,
  input wire usimd_pkg::usimd_res_s  o_res
);
  import usimd_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic go;
  assign go = i_valid & i_dsp_present & i_req.cond_pass;
  a_answer_next: assert property (i_valid |=> o_valid) else $error("late");
  a_quiet_idle: assert property (!i_valid |=> !o_valid) else $error("extra");
  a_undef_match: assert property (i_valid |=> o_res.undef == !$past(i_dsp_present))
    else $error("undef");
  a_cond_gate: assert property (i_valid |=> o_res.wr_en == $past(go))
    else $error("gate");
  a_data_keep: assert property (!o_res.wr_en |-> $stable(o_res.data))
    else $error("keep");
  a_dest_follow: assert property (go |=> o_res.wr_reg == $past(i_req.dest_reg_field))
    else $error("dest");
  a_reg_hold: assert property (!i_valid |=> $stable(o_res.wr_reg)) else $error("hold");
  a_byte_floor: assert property (go && i_req.op == usimd_sat_byte_subtract_op &&
    i_opnd.first[7:0] <= i_opnd.second[7:0] |=> o_res.data[7:0] == 8'h0) else $error("bsub");
  c_acc: cover property (o_res.eff_accumulate);
  c_undef: cover property (o_res.undef);
  c_keep: cover property (o_valid && !o_res.wr_en);
endmodule
bind usimd_alu usimd_alu_checker chk_u (.*);

// ### usimd_rf_model.sv
// Core register file model: feeds operands, takes result writes.
// Assumes port names mirror the datapath so the bench wires it by name.
`timescale 1ns/10ps
module usimd_rf_model (
  input  wire logic                   i_clk, o_valid,
  input  wire usimd_pkg::usimd_req_s  i_req,
  input  wire usimd_pkg::usimd_res_s  o_res,
  output usimd_pkg::usimd_opnd_s      i_opnd
);
  logic [31:0] rf [16];
  initial for (int k = 0; k < 16; k++) rf[k] = {8{4'(k)}};
  assign i_opnd = {rf[i_req.first_src_reg_field], rf[i_req.second_src_reg_field],
    rf[i_req.accumulator_reg_field]};
  always @(posedge i_clk) if (o_valid && o_res.wr_en) rf[o_res.wr_reg] <= o_res.data;
endmodule

// ### unsigned_simd_sat_sad_alu_tb.sv
// Bench for the SIMD datapath with hand-worked results.
// Assumes the register file model feeds the operands.
`timescale 1ns/10ps
module unsigned_simd_sat_sad_alu_tb;
  import usimd_pkg::*;
  logic        i_clk = 0, i_resetn = 0, i_dsp_present = 1, i_valid = 0, o_valid;
  logic [31:0] pa = 32'hfff00210, pb = 32'h00200113;
  usimd_req_s  i_req = '0;
  usimd_opnd_s i_opnd;
  usimd_res_s  o_res;
  int          error_cnt = 0, checked = 0;
  always #2 i_clk = ~i_clk;
  usimd_alu dut_u (.*);
  usimd_rf_model pm_u (.*);
  task automatic chk(logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h", $time, got);
    end
  endtask
  task automatic op(usimd_op_e o, logic [31:0] e, c = 32'h0, logic [3:0] f = 4'h3,
                    logic cp = 1'b1);
    @(posedge i_clk);
    pm_u.rf[1] <= pa;
    pm_u.rf[2] <= pb;
    pm_u.rf[3] <= c;
    i_valid <= 1'b1;
    i_req <= {o, 12'h412, f, cp};
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    chk(o_valid, 1'b1);
    chk(o_res.wr_en, cp & i_dsp_present);
    chk(o_res.undef, !i_dsp_present);
    chk(o_res.unpredictable, 1'b0);
    chk(o_res.eff_accumulate, o == usimd_byte_abs_diff_accumulate_op && f != 4'hf);
    chk(o_res.data, e);
  endtask
  task t_ops;
    op(usimd_sat_add_sub_exchange_op, 32'hffff01f0);
    op(usimd_sat_sub_add_exchange_op, 32'hfedd0230);
    op(usimd_sat_halfword_subtract_op, 32'hffd000fd);
    op(usimd_sat_byte_subtract_op, 32'hffd00100);
    op(usimd_byte_abs_diff_sum_op, 32'h000001d3);
    op(usimd_byte_abs_diff_accumulate_op, 32'h000001c3, 32'hfffffff0);
    op(usimd_byte_abs_diff_accumulate_op, 32'h000001d3, 32'hfffffff0, 4'hf);
    {pa, pb} = {pb, pa};
    op(usimd_sat_halfword_subtract_op, 32'h0);
    $display("ops done");
  endtask
  task t_refuse;
    op(usimd_sat_byte_subtract_op, 32'h0, 32'h0, 4'h3, 1'b0);
    @(posedge i_clk);
    i_dsp_present <= 1'b0;
    op(usimd_sat_add_sub_exchange_op, 32'h0);
    @(posedge i_clk);
    i_dsp_present <= 1'b1;
    #1;
    chk(o_valid, 1'b0);
    $display("refuse done");
  endtask
  task summarize;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_ops;
    t_refuse;
    summarize;
  end
  initial begin
    #2000;
    error_cnt++;
    summarize;
  end
endmodule
